/* src/tmc_axil_slave.sv */
/*
 AXI4-Lite slave front end: holds address and data, issues one write strobe
 and one read strobe per transfer. assumes the register file answers the
 decode combinationally from wr_addr / rd_addr.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"

module tmc_axil_slave (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wr_en,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_err,
   output logic             rd_en,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err
);

   tmc_pkg::tmc_axi_t s_r;
   tmc_pkg::tmc_axi_t s_nxt;

   assign s_axi_awready = ~s_r.aw_held;
   assign s_axi_wready  = ~s_r.w_held;
   assign s_axi_arready = ~s_r.rvalid;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign wr_en         = s_r.aw_held & s_r.w_held & ~s_r.bvalid;
   assign wr_addr       = s_r.awaddr;
   assign wr_data       = s_r.wdata;
   assign wr_strb       = s_r.wstrb;
   assign rd_en         = s_axi_arvalid & ~s_r.rvalid;
   assign rd_addr       = s_axi_araddr;

   always_comb begin
      s_nxt = s_r;
      // address and data are taken in either order
      if (s_axi_awvalid & ~s_r.aw_held) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid & ~s_r.w_held) begin
         s_nxt.w_held = 1'b1;
         s_nxt.wdata  = s_axi_wdata;
         s_nxt.wstrb  = s_axi_wstrb;
      end
      if (s_r.bvalid & s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_en) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = wr_err ? `TMC_RESP_SLVERR : `TMC_RESP_OKAY;
      end
      if (s_r.rvalid & s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_en) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = rd_data;
         s_nxt.rresp  = rd_err ? `TMC_RESP_SLVERR : `TMC_RESP_OKAY;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // tmc_axil_slave

/* src/tmc_consts.svh */
/*
 timer/counter constants: register byte offsets, field positions, reset values,
 synchroniser depth. assumes an 8-bit word-aligned AXI4-Lite byte address.
*/
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

`define TMC_ADDR_W      8
`define TMC_A_STATUS    8'h00
`define TMC_A_CTRL      8'h04
`define TMC_A_COUNT     8'h08
`define TMC_A_PRELOAD   8'h0C
`define TMC_A_PRECNT    8'h10
`define TMC_A_MCTRL     8'h14
`define TMC_A_MATCH0    8'h18
`define TMC_A_CCTRL     8'h28
`define TMC_A_CAPT0     8'h2C
`define TMC_A_OUTCTRL   8'h3C
`define TMC_A_MODE      8'h40
`define TMC_A_MASK      8'h44

`define TMC_CTRL_RUN    0
`define TMC_CTRL_CLR    1
`define TMC_MODE_EXT    0
`define TMC_ST_CAP      4
`define TMC_MC_STRIDE   3
`define TMC_MC_INT      2
`define TMC_CC_STRIDE   3
`define TMC_CC_RISE     0
`define TMC_CC_FALL     1
`define TMC_CC_INT      2
`define TMC_OC_ACT      4

`define TMC_RST_CTRL    2'h0
`define TMC_RST_PRE     32'h0000_0000
`define TMC_RST_MCTRL   12'h000
`define TMC_RST_CCTRL   12'h000
`define TMC_RST_MASK    8'hFF

`define TMC_RESP_OKAY   2'h0
`define TMC_RESP_SLVERR 2'h2
`define TMC_SYNC_STAGES 2

`endif

/* src/tmc_edge_sync.sv */
/*
 two-stage synchroniser with edge detection for one asynchronous pin.
 assumes the pin is slow against clk; pulses last one clk cycle.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"

module tmc_edge_sync #(
   parameter int SYNC = `TMC_SYNC_STAGES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   typedef struct packed {
      logic [SYNC-1:0] sync;
      logic            last;
   } tmc_es_t;

   tmc_es_t s_r;
   tmc_es_t s_nxt;

   // refuse a chain too short to synchronise
   if (SYNC < 2) begin : g_bad_sync
      $error("tmc_edge_sync needs at least two stages");
   end

   always_comb begin
      s_nxt      = s_r;
      s_nxt.sync = {s_r.sync[SYNC-2:0], pin};
      s_nxt.last = s_r.sync[SYNC-1];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rise = s_r.sync[SYNC-1] & ~s_r.last;
   assign fall = ~s_r.sync[SYNC-1] & s_r.last;

endmodule // tmc_edge_sync

/* src/tmc_pkg.sv */
/*
 timer/counter types: match and output actions, module state records.
 assumes tmc_consts.svh for numeric values.
*/
package tmc_pkg;

   typedef enum logic [1:0] {
      TMC_MA_KEEP  = 2'h0,
      TMC_MA_STOP  = 2'h1,
      TMC_MA_RESET = 2'h2
   } tmc_mact_t;

   typedef enum logic [1:0] {
      TMC_OA_NONE   = 2'h0,
      TMC_OA_LOW    = 2'h1,
      TMC_OA_HIGH   = 2'h2,
      TMC_OA_TOGGLE = 2'h3
   } tmc_oact_t;

   typedef struct packed {
      logic             aw_held;
      logic [7:0]       awaddr;
      logic             w_held;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } tmc_axi_t;

   typedef struct packed {
      logic             run;
      logic             clr;
      logic             ext_mode;
      logic [31:0]      count;
      logic [31:0]      precnt;
      logic [31:0]      preload;
      logic [11:0]      mctrl;
      logic [3:0][31:0] match;
      logic [11:0]      cctrl;
      logic [3:0][31:0] capt;
      logic [3:0]       outs;
      logic [7:0]       oact;
      logic [7:0]       status;
      logic [7:0]       mask;
   } tmc_core_t;

endpackage

/* src/tmc_timer.sv */
/*
 32-bit timer/counter with prescaler, four match channels with pin actions,
 four capture channels, sticky interrupt status and mask, AXI4-Lite registers.
 assumes ext_clk_in and cap_in are asynchronous pins, slow against clk.
*/
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "tmc_consts.svh"

// Summary of operation
// - 32-bit counter advances on internal clock or on rising external clock edges.
// - counting source passes a programmable 32-bit prescaler before the counter.
// - four software-programmed 32-bit match registers are compared with the counter.
// - on match: keep counting, stop, or clear; interrupt only if enabled.
// - four match outputs go low, high, toggle or stay on their match.
// - four capture registers latch the counter on a selected input transition.
// - a capture raises an interrupt only when enabled for that channel.
module tmc_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_clk_in,
   input  wire logic [3:0]  cap_in,
   output logic [3:0]       match_out,
   output logic             irq
);

   localparam int NCH = 4;

   tmc_pkg::tmc_core_t s_r;
   tmc_pkg::tmc_core_t s_nxt;

   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        ext_rise;
   logic [3:0]  cap_rise;
   logic [3:0]  cap_fall;

   tmc_axil_slave u_bus (
      .clk           (clk),
      .rst           (rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_err        (wr_err),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   // external count clock, synchronised and edge detected
   tmc_edge_sync u_ext (
      .clk  (clk),
      .rst  (rst),
      .pin  (ext_clk_in),
      .rise (ext_rise),
      .fall ()
   );

   for (genvar g = 0; g < NCH; g++) begin : g_cap
      tmc_edge_sync u_cap (
         .clk  (clk),
         .rst  (rst),
         .pin  (cap_in[g]),
         .rise (cap_rise[g]),
         .fall (cap_fall[g])
      );
   end

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] word(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   // read decode
   always_comb begin
      logic [7:0] a;
      a       = word(rd_addr);
      rd_data = '0;
      rd_err  = 1'b0;
      case (a)
         `TMC_A_STATUS:  rd_data = {24'h0, s_r.status};
         `TMC_A_CTRL:    rd_data = {30'h0, s_r.clr, s_r.run};
         `TMC_A_COUNT:   rd_data = s_r.count;
         `TMC_A_PRELOAD: rd_data = s_r.preload;
         `TMC_A_PRECNT:  rd_data = s_r.precnt;
         `TMC_A_MCTRL:   rd_data = {20'h0, s_r.mctrl};
         `TMC_A_CCTRL:   rd_data = {20'h0, s_r.cctrl};
         `TMC_A_OUTCTRL: rd_data = {20'h0, s_r.oact, s_r.outs};
         `TMC_A_MODE:    rd_data = {31'h0, s_r.ext_mode};
         `TMC_A_MASK:    rd_data = {24'h0, s_r.mask};
         default: begin
            rd_err = 1'b1;
            for (int i = 0; i < NCH; i++) begin
               if (a == `TMC_A_MATCH0 + 8'(4 * i)) begin
                  rd_data = s_r.match[i];
                  rd_err  = 1'b0;
               end
               if (a == `TMC_A_CAPT0 + 8'(4 * i)) begin
                  rd_data = s_r.capt[i];
                  rd_err  = 1'b0;
               end
            end
         end
      endcase
   end

   // write decode: status, count, prescale count and captures are read-only but mapped
   always_comb begin
      logic [7:0] a;
      a      = word(wr_addr);
      wr_err = 1'b1;
      case (a)
         `TMC_A_STATUS, `TMC_A_CTRL, `TMC_A_COUNT, `TMC_A_PRELOAD,
         `TMC_A_PRECNT, `TMC_A_MCTRL, `TMC_A_CCTRL, `TMC_A_OUTCTRL,
         `TMC_A_MODE, `TMC_A_MASK: wr_err = 1'b0;
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (a == `TMC_A_MATCH0 + 8'(4 * i) || a == `TMC_A_CAPT0 + 8'(4 * i)) begin
                  wr_err = 1'b0;
               end
            end
         end
      endcase
   end

   always_comb begin
      logic [7:0]  a;
      logic        src;
      logic        wrap;
      logic        adv;
      logic        any_rst;
      logic        any_stop;
      logic [3:0]  hit;
      logic [3:0]  capt_hit;
      logic [7:0]  set;
      logic [31:0] w;
      tmc_pkg::tmc_mact_t ma;
      tmc_pkg::tmc_oact_t oa;
      s_nxt    = s_r;
      a        = word(wr_addr);
      set      = '0;
      any_rst  = 1'b0;
      any_stop = 1'b0;
      hit      = '0;
      capt_hit = '0;
      ma       = tmc_pkg::TMC_MA_KEEP;
      oa       = tmc_pkg::TMC_OA_NONE;
      w        = '0;

      src  = s_r.ext_mode ? ext_rise : 1'b1;
      wrap = s_r.precnt == s_r.preload;
      adv  = s_r.run & ~s_r.clr & src & wrap;

      if (s_r.clr) begin
         s_nxt.precnt = '0;
      end else if (s_r.run & src) begin
         s_nxt.precnt = wrap ? 32'h0000_0000 : s_r.precnt + 32'h0000_0001;
      end

      for (int i = 0; i < NCH; i++) begin
         hit[i] = adv & (s_r.count == s_r.match[i]);
         ma     = tmc_pkg::tmc_mact_t'(s_r.mctrl[i*`TMC_MC_STRIDE +: 2]);
         oa     = tmc_pkg::tmc_oact_t'(s_r.oact[i*2 +: 2]);
         if (hit[i]) begin
            case (ma)
               tmc_pkg::TMC_MA_STOP:  any_stop = 1'b1;
               tmc_pkg::TMC_MA_RESET: any_rst  = 1'b1;
               default:               ;
            endcase
            set[i] = s_r.mctrl[i*`TMC_MC_STRIDE + `TMC_MC_INT];
            case (oa)
               tmc_pkg::TMC_OA_LOW:    s_nxt.outs[i] = 1'b0;
               tmc_pkg::TMC_OA_HIGH:   s_nxt.outs[i] = 1'b1;
               tmc_pkg::TMC_OA_TOGGLE: s_nxt.outs[i] = ~s_r.outs[i];
               default:                ;
            endcase
         end
         capt_hit[i] = (s_r.cctrl[i*`TMC_CC_STRIDE + `TMC_CC_RISE] & cap_rise[i])
                     | (s_r.cctrl[i*`TMC_CC_STRIDE + `TMC_CC_FALL] & cap_fall[i]);
         if (capt_hit[i]) begin
            s_nxt.capt[i] = s_r.count;
         end
         set[`TMC_ST_CAP + i] = capt_hit[i] & s_r.cctrl[i*`TMC_CC_STRIDE + `TMC_CC_INT];
      end

      if (s_r.clr) begin
         s_nxt.count = '0;
      end else if (adv) begin
         if (any_rst) begin
            s_nxt.count = '0;
         end else if (any_stop) begin
            s_nxt.run = 1'b0;
         end else begin
            s_nxt.count = s_r.count + 32'h0000_0001;
         end
      end

      if (wr_en) begin
         case (a)
            `TMC_A_CTRL: begin
               w           = merge({30'h0, s_r.clr, s_r.run}, wr_data, wr_strb);
               s_nxt.run   = w[`TMC_CTRL_RUN];
               s_nxt.clr   = w[`TMC_CTRL_CLR];
            end
            `TMC_A_PRELOAD: s_nxt.preload = merge(s_r.preload, wr_data, wr_strb);
            `TMC_A_MCTRL: begin
               w           = merge({20'h0, s_r.mctrl}, wr_data, wr_strb);
               s_nxt.mctrl = w[11:0];
            end
            `TMC_A_CCTRL: begin
               w           = merge({20'h0, s_r.cctrl}, wr_data, wr_strb);
               s_nxt.cctrl = w[11:0];
            end
            `TMC_A_OUTCTRL: begin
               w           = merge({20'h0, s_r.oact, s_r.outs}, wr_data, wr_strb);
               s_nxt.outs  = w[3:0];
               s_nxt.oact  = w[`TMC_OC_ACT +: 8];
            end
            `TMC_A_MODE: begin
               w              = merge({31'h0, s_r.ext_mode}, wr_data, wr_strb);
               s_nxt.ext_mode = w[`TMC_MODE_EXT];
            end
            `TMC_A_MASK: begin
               w          = merge({24'h0, s_r.mask}, wr_data, wr_strb);
               s_nxt.mask = w[7:0];
            end
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (a == `TMC_A_MATCH0 + 8'(4 * i)) begin
                     s_nxt.match[i] = merge(s_r.match[i], wr_data, wr_strb);
                  end
               end
            end
         endcase
      end

      // read clears status; an event in the same cycle still sets
      if (rd_en && word(rd_addr) == `TMC_A_STATUS) begin
         s_nxt.status = set;
      end else begin
         s_nxt.status = s_r.status | set;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r          <= '0;
         s_r.run      <= 1'(`TMC_RST_CTRL >> `TMC_CTRL_RUN);
         s_r.preload  <= `TMC_RST_PRE;
         s_r.mctrl    <= `TMC_RST_MCTRL;
         s_r.cctrl    <= `TMC_RST_CCTRL;
         s_r.mask     <= `TMC_RST_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign match_out = s_r.outs;
   assign irq       = |(s_r.status & s_r.mask);

endmodule // tmc_timer

/* verif/testbench.sv */
/*
 self-checking bench for tmc_timer: AXI4-Lite tasks, timer, match, capture.
 assumes tmc_pin_model drives the pins and the checker is bound.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"

module testbench;
   logic clk = 1'b0, rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF, cap_in, match_out;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, ext_clk_in, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] d;
   int mismatches = 0, num_checks = 0, t0;
   logic [7:0] ra [7] = '{`TMC_A_CTRL, `TMC_A_PRELOAD, `TMC_A_MCTRL, `TMC_A_CCTRL,
                          `TMC_A_MASK, `TMC_A_STATUS, `TMC_A_COUNT};
   logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};

   always #2 clk = ~clk;

   tmc_timer tmc_timer_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ext_clk_in(ext_clk_in), .cap_in(cap_in),
      .match_out(match_out), .irq(irq));
   tmc_pin_model tmc_pin_model_inst (.clk(clk), .ext_clk_in(ext_clk_in), .cap_in(cap_in),
      .match_out(match_out));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      resp = bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      v = rdata;
      resp = rresp;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, r);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a, d, r);
      check(d, exp);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(30000 * 4);
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      for (int i = 0; i < 7; i++) rc(ra[i], rv[i]);
      check({28'h0, match_out}, 32'h0);
      rd(8'h48, d, r);
      check({30'h0, r}, `TMC_RESP_SLVERR);
      wr(8'h48, 32'h1, r);
      check({30'h0, r}, `TMC_RESP_SLVERR);
      // prescaled timer, stop on match with interrupt
      w(`TMC_A_PRELOAD, 32'h3);
      w(`TMC_A_MATCH0, 32'h5);
      w(`TMC_A_MCTRL, 32'h5);
      w(`TMC_A_CTRL, 32'h1);
      repeat (12) @(posedge clk);
      rd(`TMC_A_COUNT, d, r);
      check({31'h0, d < 5}, 32'h1);
      repeat (40) @(posedge clk);
      rc(`TMC_A_COUNT, 32'h5);
      rc(`TMC_A_CTRL, 32'h0);
      rc(`TMC_A_PRECNT, 32'h0);
      check({31'h0, irq}, 32'h1);
      rc(`TMC_A_STATUS, 32'h1);
      check({31'h0, irq}, 32'h0);
      rc(`TMC_A_STATUS, 32'h0);
      // reset on match, keep with interrupt, all output actions
      w(`TMC_A_CTRL, 32'h2);
      w(`TMC_A_PRELOAD, 32'h0);
      w(`TMC_A_MATCH0, 32'h1);
      w(`TMC_A_MATCH0 + 8'h04, 32'h3);
      w(`TMC_A_MATCH0 + 8'h08, 32'h2);
      w(`TMC_A_MATCH0 + 8'h0C, 32'h2);
      w(`TMC_A_MCTRL, 32'h14);
      w(`TMC_A_OUTCTRL, 32'h6C9);
      w(`TMC_A_MASK, 32'h0);
      check({28'h0, match_out}, 32'h9);
      w(`TMC_A_CTRL, 32'h1);
      t0 = tmc_pin_model_inst.toggles;
      repeat (40) @(posedge clk);
      t0 = tmc_pin_model_inst.toggles - t0;
      check({31'h0, t0 >= 9 && t0 <= 11}, 32'h1);
      rd(`TMC_A_COUNT, d, r);
      check({31'h0, d <= 3}, 32'h1);
      w(`TMC_A_CTRL, 32'h0);
      check({28'h0, match_out & 4'hD}, 32'h5);
      check({31'h0, irq}, 32'h0);
      w(`TMC_A_MASK, 32'hFF);
      check({31'h0, irq}, 32'h1);
      rc(`TMC_A_STATUS, 32'h1);
      // external clock counting and captures
      w(`TMC_A_MODE, 32'h1);
      w(`TMC_A_MCTRL, 32'h0);
      w(`TMC_A_CTRL, 32'h2);
      w(`TMC_A_CTRL, 32'h1);
      w(`TMC_A_CCTRL, 32'h142);
      tmc_pin_model_inst.pulse_ext(7);
      rc(`TMC_A_COUNT, 32'h7);
      tmc_pin_model_inst.set_cap(2, 1'b1);
      rc(`TMC_A_CAPT0 + 8'h08, 32'h7);
      tmc_pin_model_inst.pulse_ext(3);
      tmc_pin_model_inst.set_cap(0, 1'b1);
      rc(`TMC_A_CAPT0, 32'h0);
      tmc_pin_model_inst.set_cap(0, 1'b0);
      rc(`TMC_A_CAPT0, 32'hA);
      check({31'h0, irq}, 32'h1);
      rc(`TMC_A_STATUS, 32'h40);
      // byte lanes: only the low byte of the preload may change
      wstrb <= 4'h1;
      w(`TMC_A_PRELOAD, 32'hFFFF_FF05);
      wstrb <= 4'hF;
      rc(`TMC_A_PRELOAD, 32'h0000_0005);
      report_and_stop();
   end
endmodule // testbench

/* verif/tmc_pin_model.sv */
/*
 pin-side model: external count clock, capture pins, match output watcher.
 assumes its tasks are called just after a rising clk edge.
*/
`timescale 1ns/10ps

module tmc_pin_model (
   input  wire logic       clk,
   output logic            ext_clk_in,
   output logic [3:0]      cap_in,
   input  wire logic [3:0] match_out
);
   int   toggles = 0;
   logic prev    = 1'b0;

   initial begin
      ext_clk_in = 1'b0;
      cap_in     = 4'h0;
   end

   // slow pulses, clock idle low between them
   task automatic pulse_ext(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk);
         ext_clk_in <= 1'b1;
         repeat (4) @(posedge clk);
         ext_clk_in <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic set_cap(input int ch, input logic v);
      cap_in[ch] <= v;
      repeat (8) @(posedge clk);
   endtask

   // counts changes of match output 1
   always @(posedge clk) begin
      prev <= match_out[1];
      if (match_out[1] !== prev) toggles <= toggles + 1;
   end
endmodule // tmc_pin_model

/* verif/tmc_timer_assertions.sv */
/*
 concurrent checks on the timer's register bus and interrupt pin.
 assumes it is bound to tmc_timer and sees only its ports.
*/
`timescale 1ns/10ps
`include "tmc_consts.svh"

module tmc_timer_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;

   property p_aw_hold; aw_take |=> !s_axi_awready; endproperty
   a_aw_hold: assert property (p_aw_hold) else $error("awready high after address taken");
   property p_w_hold; w_take |=> !s_axi_wready; endproperty
   a_w_hold: assert property (p_w_hold) else $error("wready high after data taken");
   property p_b_after; aw_take && w_take && !s_axi_bvalid |-> ##2 s_axi_bvalid; endproperty
   a_b_after: assert property (p_b_after) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_after; ar_take |=> s_axi_rvalid; endproperty
   a_r_after: assert property (p_r_after) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_rdy; s_axi_arready == !s_axi_rvalid; endproperty
   a_ar_rdy: assert property (p_ar_rdy) else $error("arready not inverse of rvalid");
   property p_slverr;
      ar_take && (s_axi_araddr[7:2] > 6'h11) |=> s_axi_rresp == `TMC_RESP_SLVERR;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
   property p_okay;
      ar_take && (s_axi_araddr[7:2] <= 6'h11) |=> s_axi_rresp == `TMC_RESP_OKAY;
   endproperty
   a_okay: assert property (p_okay) else $error("mapped read refused");
   property p_irq_fall; $fell(irq) |-> s_axi_rvalid || s_axi_bvalid; endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_err:   cover property (s_axi_rvalid && s_axi_rresp == `TMC_RESP_SLVERR);
   c_irq:   cover property ($rose(irq));
endmodule // tmc_timer_assertions

bind tmc_timer tmc_timer_assertions tmc_timer_assertions_inst (
   .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq(irq)
);
